// File: rtl/adc_host.v
/*
 Host controller that drives a two-pass 10-bit converter through its
 select, sample/hold and read strobes and collects each result.
 Assumes the converter pins are wired directly; done and data are async.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_host_consts.vh"
module adc_host #(
   parameter DATA_W = 10
) (
   input wire REF_CLK, // 40 MHz clock
   input wire RST, // Sync reset, active high
   input wire START, // Request one conversion (pulse)
   input wire MODE, // 0 strobe mode, 1 read mode
   output reg BUSY, // Conversion in progress
   output reg [DATA_W-1:0] RESULT, // Last unsigned result
   output reg RESULT_VALID, // One-cycle pulse with new result
   output reg TIMEOUT, // One-cycle pulse: done never came
   output reg CS_N, // Chip select, active low
   output reg SH_N, // Sample/hold strobe, active low
   output reg RD_N, // Read strobe, active low
   input wire DONE_N, // Converter done line, active low
   input wire [DATA_W-1:0] DATA_IN // Converter data pins
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_SAMPLE = 3'h1;
   localparam [2:0] S_WAIT = 3'h2;
   localparam [2:0] S_READ = 3'h3;
   localparam [2:0] S_RELEASE = 3'h4;
   localparam [2:0] S_GAP = 3'h5;
   // Cycle counts kept 32 bits wide, then trimmed to the counter width
   localparam [31:0] SAMPLE_W32 = `SAMPLE_LOW_CYC;
   localparam [31:0] STROBE_W32 = `STROBE_CONV_CYC;
   localparam [31:0] READ_W32 = `READ_CONV_CYC;
   localparam [31:0] DATA_W32 = `DATA_AFTER_DONE_CYC;
   localparam [31:0] REL_W32 = `RELEASE_CYC;
   localparam [31:0] GAP_W32 = `GAP_CYC;
   localparam [7:0] SAMPLE_CYC = SAMPLE_W32[7:0];
   localparam [7:0] STROBE_CYC = STROBE_W32[7:0];
   localparam [7:0] READ_CYC = READ_W32[7:0];
   localparam [7:0] DATA_CYC = DATA_W32[7:0];
   localparam [7:0] REL_CYC = REL_W32[7:0];
   localparam [7:0] GAP_CYC = GAP_W32[7:0];
   // Margin for synchroniser latency on the done line
   localparam [7:0] SYNC_MARGIN = 8'h04;

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   reg mode_ff;
   reg nxt_mode;
   wire done_n_s;
   wire [DATA_W-1:0] data_s;
   reg nxt_cs_n;
   reg nxt_sh_n;
   reg nxt_rd_n;
   reg nxt_busy;
   reg nxt_timeout;
   reg nxt_capture;
   wire [7:0] wait_limit;

   // Done timeout: longest conversion plus synchroniser delay
   assign wait_limit = ((mode_ff == `MODE_READ) ? READ_CYC : STROBE_CYC) + SYNC_MARGIN;

   // ==========================================
   // Pin synchronisers
   pin_sync3 #(.RST_VAL(1'b1)) u_done_sync (
      .clk(REF_CLK),
      .rst(RST),
      .din(DONE_N),
      .dout(done_n_s)
   );
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_dsync
         pin_sync3 #(.RST_VAL(1'b0)) u_data_sync (
            .clk(REF_CLK),
            .rst(RST),
            .din(DATA_IN[gi]),
            .dout(data_s[gi])
         );
      end
   endgenerate

   // ==========================================
   // Sequencer
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_mode = mode_ff;
      case (state_ff)
         S_IDLE: begin
            if (START) begin
               nxt_mode = MODE;
               nxt_cnt = 8'h00;
               nxt_state = S_SAMPLE;
            end
         end
         S_SAMPLE: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (mode_ff == `MODE_READ) begin
               nxt_cnt = 8'h00;
               nxt_state = S_WAIT;
            end else if (cnt_ff >= SAMPLE_CYC - 8'h01) begin
               nxt_cnt = 8'h00;
               nxt_state = S_WAIT;
            end
         end
         S_WAIT: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (!done_n_s) begin
               nxt_cnt = 8'h00;
               nxt_state = S_READ;
            end else if (cnt_ff >= wait_limit) begin
               nxt_cnt = 8'h00;
               nxt_state = S_RELEASE;
            end
         end
         S_READ: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff >= DATA_CYC + SYNC_MARGIN) begin
               nxt_cnt = 8'h00;
               nxt_state = S_RELEASE;
            end
         end
         S_RELEASE: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff >= REL_CYC - 8'h01) begin
               nxt_cnt = 8'h00;
               nxt_state = S_GAP;
            end
         end
         S_GAP: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff >= GAP_CYC - 8'h01) begin
               nxt_cnt = 8'h00;
               nxt_state = S_IDLE;
            end
         end
         default: begin
            nxt_cnt = 8'h00;
            nxt_state = S_IDLE;
         end
      endcase
   end

   // ==========================================
   // Pin and flag decode
   // Pins are registered from the next state so they never glitch
   always @* begin
      nxt_busy = (nxt_state != S_IDLE);
      // Timeout and capture end the wait and read states
      nxt_timeout = (state_ff == S_WAIT) && (nxt_state == S_RELEASE);
      nxt_capture = (state_ff == S_READ) && (nxt_state == S_RELEASE);
      // Select low with any strobe low
      nxt_cs_n = !((nxt_state == S_SAMPLE) || (nxt_state == S_READ) ||
                   (nxt_state == S_WAIT && nxt_mode == `MODE_READ));
      // Joined strobes in read mode: one sample per conversion
      nxt_sh_n = !((nxt_state == S_SAMPLE) ||
                   (nxt_mode == `MODE_READ &&
                    (nxt_state == S_WAIT || nxt_state == S_READ)));
      // Read strobe follows sample/hold in read mode
      nxt_rd_n = !((nxt_state == S_READ) ||
                   (nxt_mode == `MODE_READ &&
                    (nxt_state == S_SAMPLE || nxt_state == S_WAIT)));
   end

   // ==========================================
   // State and pin registers
   always @(posedge REF_CLK) begin
      if (RST) begin
         state_ff <= S_IDLE;
         cnt_ff <= 8'h00;
         mode_ff <= `MODE_STROBE;
         BUSY <= 1'b0;
         RESULT <= {DATA_W{1'b0}};
         RESULT_VALID <= 1'b0;
         TIMEOUT <= 1'b0;
         CS_N <= 1'b1;
         SH_N <= 1'b1;
         RD_N <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         mode_ff <= nxt_mode;
         BUSY <= nxt_busy;
         RESULT_VALID <= nxt_capture;
         TIMEOUT <= nxt_timeout;
         CS_N <= nxt_cs_n;
         SH_N <= nxt_sh_n;
         RD_N <= nxt_rd_n;
         // Result taken once the synchronised data has settled
         if (nxt_capture) begin
            RESULT <= data_s;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/adc_host_consts.vh
/*
 Timing constants and mode codes for the converter host controller.
 Assumes a 40 MHz reference clock (25 ns period).
*/
`ifndef ADC_HOST_CONSTS_VH
`define ADC_HOST_CONSTS_VH

// ==========================================
// Clock
`define CLK_PERIOD_NS 25

// ==========================================
// Times in ns
`define SAMPLE_LOW_NS 250
`define STROBE_CONV_MAX_NS 1800
`define READ_CONV_MAX_NS 2400
`define DATA_AFTER_DONE_NS 50
`define RELEASE_NS 50
`define GAP_NS 20

// ==========================================
// Cycle counts (least times round up, longest round down)
`define SAMPLE_LOW_CYC ((`SAMPLE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CONV_CYC (`STROBE_CONV_MAX_NS / `CLK_PERIOD_NS)
`define READ_CONV_CYC (`READ_CONV_MAX_NS / `CLK_PERIOD_NS)
`define DATA_AFTER_DONE_CYC ((`DATA_AFTER_DONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_CYC ((`RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================
// Interface modes
`define MODE_STROBE 1'b0
`define MODE_READ 1'b1

`endif

// File: rtl/pin_sync3.v
/*
 Three-stage synchroniser for one pin; a change counts once stages 2 and 3 agree.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
   parameter RST_VAL = 1'b1
) (
   input wire clk, // Clock
   input wire rst, // Sync reset
   input wire din, // Asynchronous pin
   output reg dout // Filtered level
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge clk) begin
      if (rst) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            dout <= s3_ff;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/adc_host_assertions.sv
/* Checker on the host pins of adc_host.
   Assumes one clock domain and bind into every adc_host. */
`timescale 1ns/100ps
`default_nettype none
module adc_host_assertions (
   input wire logic REF_CLK, // Clock
   input wire logic RST, // Sync reset
   input wire logic RESULT_VALID, // New result pulse
   input wire logic CS_N, // Chip select
   input wire logic SH_N, // Sample strobe
   input wire logic RD_N, // Read strobe
   input wire logic DONE_N // Done line
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   property p_sh_len; $rose(SH_N) |-> !$past(SH_N, 10); endproperty
   a_sh_len: assert property (p_sh_len) else $error("sample strobe short");
   property p_rd_after; $fell(RD_N) && SH_N |-> !DONE_N; endproperty
   a_rd_after: assert property (p_rd_after) else $error("read before done");
   property p_sel; !SH_N || !RD_N |-> !CS_N; endproperty
   a_sel: assert property (p_sel) else $error("strobe without select");
   property p_joined; !SH_N && !RD_N |=> SH_N == RD_N; endproperty
   a_joined: assert property (p_joined) else $error("joined strobes split");
   property p_valid; RESULT_VALID |-> $rose(RD_N) && !$past(DONE_N, 5); endproperty
   a_valid: assert property (p_valid) else $error("result before done");
   property p_gap; $rose(CS_N) |=> CS_N[*2]; endproperty
   a_gap: assert property (p_gap) else $error("no gap after cycle");
endmodule
bind adc_host adc_host_assertions u_chk(.REF_CLK(REF_CLK), .RST(RST),
   .RESULT_VALID(RESULT_VALID), .CS_N(CS_N), .SH_N(SH_N), .RD_N(RD_N), .DONE_N(DONE_N));
`default_nettype wire

// File: testbench/conv_model.sv
/* Behavioural two-pass converter on the far side of adc_host.
   Assumes conv_ns is stable for the whole conversion. */
`timescale 1ns/100ps
`default_nettype none
module conv_model (
   input wire logic cs_n, // Chip select
   input wire logic sh_n, // Sample strobe
   input wire logic rd_n, // Read strobe
   input wire logic [9:0] vin, // Input level as code
   input wire logic [31:0] conv_ns, // Conversion time
   output logic done_n, // Done line
   output logic [9:0] dout // Data pins
);
   logic [9:0] held;
   logic [9:0] res = 10'h000;
   logic valid = 1'b0;
   logic joined;
   initial done_n = 1'b1;
   assign dout = (!cs_n && !rd_n && valid) ? res : ~res;
   // Pins settle first: select and both strobes move in one time step
   always @(negedge sh_n) begin
      #1;
      if (!cs_n && !sh_n) begin
         held = vin;
         joined = !rd_n;
         done_n = 1'b1;
         valid = 1'b0;
         if (!joined) begin
            @(posedge sh_n);
            #1;
         end
         #(conv_ns);
         res = {held[9:4], held[3:0]};
         done_n = 1'b0;
         #20 valid = 1'b1;
      end
   end
   always @(posedge rd_n) begin
      #10 done_n = 1'b1;
      valid = 1'b0;
   end
endmodule
`default_nettype wire

// File: testbench/adc_host_bench.sv
/* Self-checking bench for adc_host against conv_model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/100ps
`default_nettype none
module adc_host_bench;
   logic clk = 1'b0, rst = 1'b1, start = 1'b0, mode = 1'b0;
   logic busy, rv, tmo, cs_n, sh_n, rd_n, done_n;
   logic [9:0] result, data;
   logic [9:0] vin = 10'h000;
   logic [31:0] conv_ns = 32'd1200;
   int n_errors = 0, compares = 0;
   logic [10:0] got;
   always #12.5 clk = ~clk;
   adc_host u_dut(.REF_CLK(clk), .RST(rst), .START(start), .MODE(mode), .BUSY(busy),
      .RESULT(result), .RESULT_VALID(rv), .TIMEOUT(tmo), .CS_N(cs_n), .SH_N(sh_n),
      .RD_N(rd_n), .DONE_N(done_n), .DATA_IN(data));
   conv_model u_conv(.cs_n(cs_n), .sh_n(sh_n), .rd_n(rd_n), .vin(vin), .conv_ns(conv_ns),
      .done_n(done_n), .dout(data));
   // ==========================================
   // Shared tasks
   task automatic check(input logic [10:0] g, input logic [10:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic run(input logic m, input logic [9:0] v, input int ns);
      int k;
      k = 0;
      mode = m;
      vin = v;
      conv_ns = ns;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      check({10'h000, busy}, 11'h001);
      while (!rv && !tmo && k < 200) begin
         @(posedge clk);
         #1 k++;
      end
      // A limit that runs out gives a code no scenario expects
      got = (!rv && !tmo) ? 11'h7ff : {tmo, rv ? result : 10'h000};
      repeat (40) @(posedge clk);
      #1;
      check({10'h000, busy}, 11'h000);
   endtask
   task automatic end_sim;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_strobe;
      run(1'b0, 10'h000, 1200);
      check(got, 11'h000);
      run(1'b0, 10'h3ff, 1750);
      check(got, 11'h3ff);
      run(1'b0, 10'h2a5, 1200);
      check(got, 11'h2a5);
      $display("test strobe done");
   endtask
   task automatic t_read;
      run(1'b1, 10'h15a, 1800);
      check(got, 11'h15a);
      run(1'b1, 10'h0c3, 2350);
      check(got, 11'h0c3);
      $display("test read done");
   endtask
   task automatic t_timeout;
      run(1'b1, 10'h111, 3000);
      check(got, 11'h400);
      run(1'b0, 10'h222, 1200);
      check(got, 11'h222);
      $display("test timeout done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      t_strobe();
      t_read();
      t_timeout();
      end_sim();
   end
   initial begin
      #60000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
